/* File: imld_pkg.sv */
// Package with constants and carrier types for the indexed byte load decoder.
package imld_pkg;

  localparam logic [7:0] PREFIX_EXT = 8'hce;
  localparam logic [7:0] OP_ABS_FROM_SECOND = 8'h7f;
  localparam logic [7:0] OP_PTR_FROM_SECOND = 8'h6f;
  localparam logic [7:0] OP_FIRST_FROM_SECOND = 8'h67;
  localparam logic [7:0] OP_SECOND_FROM_SECOND = 8'h77;
  localparam logic [2:0] GRP_TO_REG = 3'h2;
  localparam logic [2:0] GRP_TO_MEM = 3'h3;
  localparam logic [1:0] DST_PTR = 2'h0;
  localparam logic [1:0] DST_FIRST = 2'h1;
  localparam logic [1:0] DST_SECOND = 2'h3;
  localparam logic [1:0] SRC_FIRST_DISP = 2'h0;
  localparam logic [1:0] SRC_SECOND_DISP = 2'h1;
  localparam logic [1:0] SRC_FIRST_LOW = 2'h2;
  localparam logic [1:0] SRC_SECOND_LOW = 2'h3;
  localparam logic [7:0] PAGE_SMALL = 8'h00;
  localparam logic [23:0] ADDR_RESET = 24'h000000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [1:0] {
    IMLD_IDLE = 2'b00,
    IMLD_READ = 2'b01,
    IMLD_WRITE = 2'b10
  } imld_state_e;

  // Register values that the core presents with each instruction.
  typedef struct packed {
    logic [7:0] pageBase;
    logic [7:0] expandPage;
    logic [7:0] firstIndexPage;
    logic [7:0] secondIndexPage;
    logic [15:0] firstIndex;
    logic [15:0] secondIndex;
    logic [15:0] pointerPair;
  } imld_regs_s;

  // One instruction handed over by the fetch stage.
  typedef struct packed {
    logic prefixed;
    logic [7:0] opcode;
    logic [7:0] operand;
  } imld_instr_s;

  typedef struct packed {
    imld_state_e state;
    logic [23:0] dstAddr;
    logic toReg;
    logic busy;
    logic memReq;
    logic memWe;
    logic [23:0] memAddr;
    logic [7:0] memWdata;
    logic regWe;
    logic [1:0] regSel;
    logic [7:0] regData;
    logic done;
    logic illegal;
  } imld_core_s;

endpackage

/* File: imld_decode.sv */
// Decoder and sequencer for the indexed and page-based byte load group.
// Notes on behaviour
// - Opcode 7FH with one absolute byte copies [second index] to {page base, absolute byte}.
// - In the large models the absolute target uses the expand page and the second-index source its own page.
// - Opcode 6FH copies [second index] to the pointer pair address, expand page for target, second index page for source.
// - Opcodes 67H and 77H copy [second index] to the first or second index address, paged by that register's page.
// - Every displacement byte is a signed value from -128 to 127 added to the index register.
// - Working register loads from first index plus displacement use the first index page in large models.
// - Prefix CEH with 68H or 78H copies [first index plus displacement] to the address of the selected index register.
// - Prefix CEH with 41H, 49H, 51H or 59H loads A, B, L or H from second index plus displacement, second index page.
// - Prefix CEH with 61H copies [second index plus displacement] to the pointer pair, expand page for the target.
// - Prefix CEH with 69H or 79H copies [second index plus displacement] to the selected index register address.
// - Prefix CEH with 42H, 4AH, 52H or 5AH loads a working register from first index plus low pointer byte.
// - The low pointer byte used as an offset is sign extended to -128..127 before the add.
// - Prefix CEH with 62H copies [first index plus low pointer byte] to the pointer pair address.
// - Prefix CEH with 6AH or 7AH copies [first index plus low pointer byte] to the selected index register address.
// - Prefix CEH with 43H, 4BH, 53H or 5BH loads a working register from second index plus low pointer byte.
`timescale 1ns/1ps
`default_nettype none

module imld_decode (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic largeModel,
  input wire logic instrStart,
  input wire imld_pkg::imld_instr_s instr,
  input wire imld_pkg::imld_regs_s regs,
  input wire logic memAck,
  input wire logic [7:0] memRdata,
  output logic busy,
  output logic memReq,
  output logic memWe,
  output logic [23:0] memAddr,
  output logic [7:0] memWdata,
  output logic regWe,
  output logic [1:0] regSel,
  output logic [7:0] regData,
  output logic done,
  output logic illegal
);

  imld_pkg::imld_core_s core_reg;
  imld_pkg::imld_core_s core_next;

  logic [7:0] pgExpand;
  logic [7:0] pgFirst;
  logic [7:0] pgSecond;
  logic [15:0] offsetExt;
  logic [1:0] srcMode;
  logic [2:0] opGroup;
  logic [1:0] dstField;
  logic legal;
  logic destIsReg;
  logic [23:0] srcAddr;
  logic [23:0] dstAddr;

  // Small models see page zero; large models take the page registers as they stand.
  assign pgExpand = largeModel ? regs.expandPage : imld_pkg::PAGE_SMALL;
  assign pgFirst = largeModel ? regs.firstIndexPage : imld_pkg::PAGE_SMALL;
  assign pgSecond = largeModel ? regs.secondIndexPage : imld_pkg::PAGE_SMALL;
  assign srcMode = instr.opcode[1:0];
  assign opGroup = instr.opcode[7:5];
  assign dstField = instr.opcode[4:3];

  always_comb begin
    logic [7:0] offsetByte;
    offsetByte = instr.operand;
    if (srcMode[1]) begin
      offsetByte = regs.pointerPair[7:0];
    end
    offsetExt = {{8{offsetByte[7]}}, offsetByte};
  end

  always_comb begin
    legal = 1'b0;
    destIsReg = 1'b0;
    srcAddr = imld_pkg::ADDR_RESET;
    dstAddr = imld_pkg::ADDR_RESET;
    if (!instr.prefixed) begin
      srcAddr = {pgSecond, regs.secondIndex};
      unique case (instr.opcode)
        imld_pkg::OP_ABS_FROM_SECOND: begin
          legal = 1'b1;
          dstAddr = {pgExpand, regs.pageBase, instr.operand};
        end
        imld_pkg::OP_PTR_FROM_SECOND: begin
          legal = 1'b1;
          dstAddr = {pgExpand, regs.pointerPair};
        end
        imld_pkg::OP_FIRST_FROM_SECOND: begin
          legal = 1'b1;
          dstAddr = {pgFirst, regs.firstIndex};
        end
        imld_pkg::OP_SECOND_FROM_SECOND: begin
          legal = 1'b1;
          dstAddr = {pgSecond, regs.secondIndex};
        end
        default: begin
          legal = 1'b0;
        end
      endcase
    end else if (instr.opcode[2] == 1'b0) begin
      // The page byte is concatenated after the 16-bit sum, so a carry never reaches it.
      unique case (srcMode)
        imld_pkg::SRC_FIRST_DISP: srcAddr = {pgFirst, 16'(regs.firstIndex + offsetExt)};
        imld_pkg::SRC_SECOND_DISP: srcAddr = {pgSecond, 16'(regs.secondIndex + offsetExt)};
        imld_pkg::SRC_FIRST_LOW: srcAddr = {pgFirst, 16'(regs.firstIndex + offsetExt)};
        imld_pkg::SRC_SECOND_LOW: srcAddr = {pgSecond, 16'(regs.secondIndex + offsetExt)};
      endcase
      if (opGroup == imld_pkg::GRP_TO_REG) begin
        legal = 1'b1;
        destIsReg = 1'b1;
      end else if (opGroup == imld_pkg::GRP_TO_MEM) begin
        unique case (dstField)
          imld_pkg::DST_PTR: begin
            legal = 1'b1;
            dstAddr = {pgExpand, regs.pointerPair};
          end
          imld_pkg::DST_FIRST: begin
            legal = 1'b1;
            dstAddr = {pgFirst, regs.firstIndex};
          end
          imld_pkg::DST_SECOND: begin
            legal = 1'b1;
            dstAddr = {pgSecond, regs.secondIndex};
          end
          default: begin
            legal = 1'b0;
          end
        endcase
      end
    end
  end

  always_comb begin
    core_next = core_reg;
    core_next.done = 1'b0;
    core_next.illegal = 1'b0;
    core_next.regWe = 1'b0;
    unique case (core_reg.state)
      imld_pkg::IMLD_IDLE: begin
        if (instrStart) begin
          if (legal) begin
            core_next.state = imld_pkg::IMLD_READ;
            core_next.busy = 1'b1;
            core_next.memReq = 1'b1;
            core_next.memWe = 1'b0;
            core_next.memAddr = srcAddr;
            core_next.dstAddr = dstAddr;
            core_next.toReg = destIsReg;
            core_next.regSel = dstField;
          end else begin
            core_next.illegal = 1'b1;
            core_next.done = 1'b1;
          end
        end
      end
      imld_pkg::IMLD_READ: begin
        if (memAck) begin
          if (core_reg.toReg) begin
            // Only the data register is written; no flag update exists on this path.
            core_next.regWe = 1'b1;
            core_next.regData = memRdata;
            core_next.memReq = 1'b0;
            core_next.busy = 1'b0;
            core_next.done = 1'b1;
            core_next.state = imld_pkg::IMLD_IDLE;
          end else begin
            core_next.memWe = 1'b1;
            core_next.memAddr = core_reg.dstAddr;
            core_next.memWdata = memRdata;
            core_next.state = imld_pkg::IMLD_WRITE;
          end
        end
      end
      imld_pkg::IMLD_WRITE: begin
        if (memAck) begin
          core_next.memReq = 1'b0;
          core_next.memWe = 1'b0;
          core_next.busy = 1'b0;
          core_next.done = 1'b1;
          core_next.state = imld_pkg::IMLD_IDLE;
        end
      end
      default: begin
        core_next.state = imld_pkg::IMLD_IDLE;
        core_next.memReq = 1'b0;
        core_next.memWe = 1'b0;
        core_next.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      core_reg.state <= imld_pkg::IMLD_IDLE;
      core_reg.dstAddr <= imld_pkg::ADDR_RESET;
      core_reg.toReg <= 1'b0;
      core_reg.busy <= 1'b0;
      core_reg.memReq <= 1'b0;
      core_reg.memWe <= 1'b0;
      core_reg.memAddr <= imld_pkg::ADDR_RESET;
      core_reg.memWdata <= imld_pkg::BYTE_RESET;
      core_reg.regWe <= 1'b0;
      core_reg.regSel <= 2'h0;
      core_reg.regData <= imld_pkg::BYTE_RESET;
      core_reg.done <= 1'b0;
      core_reg.illegal <= 1'b0;
    end else begin
      core_reg <= core_next;
    end
  end

  assign busy = core_reg.busy;
  assign memReq = core_reg.memReq;
  assign memWe = core_reg.memWe;
  assign memAddr = core_reg.memAddr;
  assign memWdata = core_reg.memWdata;
  assign regWe = core_reg.regWe;
  assign regSel = core_reg.regSel;
  assign regData = core_reg.regData;
  assign done = core_reg.done;
  assign illegal = core_reg.illegal;

endmodule

`default_nettype wire

/* File: imld_mem_model.sv */
// Behavioural data memory that answers the decoder's bus after a chosen delay.
`timescale 1ns/1ps
`default_nettype none
module imld_mem_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [23:0] memAddr,
  input wire logic [1:0] lat,
  output logic memAck,
  output logic [7:0] memRdata
);
  logic [1:0] waitCnt;
  // Outside an answer the data lines toggle, so a stale byte never passes for read data.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      memAck <= 1'b0;
      memRdata <= 8'h00;
      waitCnt <= 2'h0;
    end else if (memReq && !memAck) begin
      memAck <= waitCnt == lat;
      waitCnt <= (waitCnt == lat) ? 2'h0 : waitCnt + 2'h1;
      memRdata <= (waitCnt == lat) ? memAddr[7:0] ^ memAddr[23:16] ^ 8'h3c : ~memRdata;
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
    end
  end
endmodule
`default_nettype wire

/* File: imld_monitor.sv */
// Concurrent checks on the ports of the indexed byte load decoder.
`timescale 1ns/1ps
`default_nettype none
module imld_monitor (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic largeModel,
  input wire logic instrStart,
  input wire logic memAck,
  input wire logic busy,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic regWe,
  input wire logic done,
  input wire logic illegal,
  input wire imld_pkg::imld_instr_s instr,
  input wire imld_pkg::imld_regs_s regs,
  input wire logic [7:0] memRdata,
  input wire logic [7:0] memWdata,
  input wire logic [7:0] regData,
  input wire logic [23:0] memAddr
);
  logic take;
  assign take = instrStart && !busy;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_src; take && !instr.prefixed && instr.opcode inside {8'h7f, 8'h6f, 8'h67, 8'h77} |=> memReq && !memWe
    && memAddr == {$past(largeModel) ? $past(regs.secondIndexPage) : 8'h00, $past(regs.secondIndex)}; endproperty
  a_src: assert property (p_src) else $error("wrong source address");
  property p_disp; take && instr.prefixed && instr.opcode[7:5] == 3'h2 && instr.opcode[2:0] == 3'h1 |=> memReq
    && memAddr == {$past(largeModel) ? $past(regs.secondIndexPage) : 8'h00,
    $past(regs.secondIndex) + {{8{$past(instr.operand[7])}}, $past(instr.operand)}}; endproperty
  a_disp: assert property (p_disp) else $error("wrong displaced address");
  property p_low; take && instr.prefixed && instr.opcode == 8'h42 |=> memAddr == {$past(largeModel) ?
    $past(regs.firstIndexPage) : 8'h00,
    $past(regs.firstIndex) + {{8{$past(regs.pointerPair[7])}}, $past(regs.pointerPair[7:0])}}; endproperty
  a_low: assert property (p_low) else $error("wrong offset address");
  property p_wd; memReq && memAck && !memWe ##1 memWe |-> memWdata == $past(memRdata); endproperty
  a_wd: assert property (p_wd) else $error("write data differs from read");
  property p_reg; regWe |-> done && !illegal && regData == $past(memRdata); endproperty
  a_reg: assert property (p_reg) else $error("bad register load");
  property p_hold; memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe); endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_ill; take && !instr.prefixed && instr.opcode[7:4] == 4'h0 |=> done && illegal && !memReq; endproperty
  a_ill: assert property (p_ill) else $error("foreign opcode not refused");
  property p_fin; memReq && memAck && memWe |=> done && !busy && !memReq && !illegal; endproperty
  a_fin: assert property (p_fin) else $error("copy did not finish");
  c_copy: cover property (memReq && memAck && memWe);
  c_reg: cover property (regWe);
  c_ill: cover property (illegal);
endmodule
bind imld_decode imld_monitor mon (.mclk(mclk), .sys_rst(sys_rst), .largeModel(largeModel), .instrStart(instrStart),
  .memAck(memAck), .busy(busy), .memReq(memReq), .memWe(memWe), .regWe(regWe), .done(done), .illegal(illegal),
  .instr(instr), .regs(regs), .memRdata(memRdata), .memWdata(memWdata), .regData(regData), .memAddr(memAddr));
`default_nettype wire

/* File: indexed_memory_load_decode_tb_top.sv */
// Self-checking bench for the indexed byte load decoder.
`timescale 1ns/1ps
`default_nettype none
module indexed_memory_load_decode_tb_top;
  logic mclk = 1'b0, sys_rst = 1'b1, largeModel = 1'b0, instrStart = 1'b0;
  imld_pkg::imld_instr_s instr = '0;
  imld_pkg::imld_regs_s regs = '0;
  logic [1:0] lat = 2'h0, regSel;
  logic memAck, memReq, memWe, busy, regWe, done, illegal;
  logic [7:0] memRdata, memWdata, regData;
  logic [23:0] memAddr;
  int failures = 0, n_compared = 0;
  logic hung = 1'b0;
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  imld_decode uut (.mclk(mclk), .sys_rst(sys_rst), .largeModel(largeModel), .instrStart(instrStart), .instr(instr),
    .regs(regs), .memAck(memAck), .memRdata(memRdata), .busy(busy), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .regWe(regWe), .regSel(regSel), .regData(regData), .done(done), .illegal(illegal));
  imld_mem_model mem (.mclk(mclk), .sys_rst(sys_rst), .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .lat(lat),
    .memAck(memAck), .memRdata(memRdata));
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp) failures++;
    if (seen !== exp) $display("unexpected %s expected %h seen %h", what, exp, seen);
  endtask
  function automatic logic [23:0] loc(input logic [7:0] pg, input logic [15:0] a);
    return {largeModel ? pg : 8'h00, a};
  endfunction
  task automatic run(input logic p, input logic [7:0] op, od);
    imld_pkg::imld_regs_s r;
    logic [23:0] src, dst, sSrc, sDst;
    logic [7:0] sWd, sReg, dat;
    logic [1:0] sSel;
    logic sIll, ok, legal, sBusy;
    int off;
    r = 88'({$urandom(), $urandom(), $urandom()});
    {sSrc, sDst, sWd, sReg, sSel, sIll} = 'x;
    @(posedge mclk);
    instrStart <= 1'b1;
    instr <= {p, op, od};
    regs <= r;
    largeModel <= 1'($urandom());
    lat <= 2'($urandom() % 3);
    @(posedge mclk);
    instrStart <= 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge mclk);
      if (i == 0) sBusy = busy;
      if (memReq === 1'b1 && memAck === 1'b1 && memWe === 1'b1) {sDst, sWd} = {memAddr, memWdata};
      if (memReq === 1'b1 && memAck === 1'b1 && memWe === 1'b0) sSrc = memAddr;
      if (regWe === 1'b1) {sReg, sSel} = {regData, regSel};
      if (done === 1'b1) {ok, sIll} = {1'b1, illegal};
    end
    // A hung transfer is counted and ends the scenario list; the verdict is given once, by the caller.
    if (!ok) begin
      failures++;
      hung = 1'b1;
      return;
    end
    off = op[1] ? int'($signed(r.pointerPair[7:0])) : int'($signed(od));
    legal = p ? !op[2] && (op[7:5] == 3'h2 || op[7:5] == 3'h3 && op[4:3] != 2'h2) : op inside {8'h7f, 8'h6f, 8'h67, 8'h77};
    src = op[0] ? loc(r.secondIndexPage, 16'(int'(r.secondIndex) + off)) : loc(r.firstIndexPage, 16'(int'(r.firstIndex) + off));
    if (!p) src = loc(r.secondIndexPage, r.secondIndex);
    dst = op[4] ? loc(r.secondIndexPage, r.secondIndex) : loc(r.firstIndexPage, r.firstIndex);
    if (p ? op[4:3] == 2'h0 : op == 8'h6f) dst = loc(r.expandPage, r.pointerPair);
    if (!p && op == 8'h7f) dst = loc(r.expandPage, {r.pageBase, od});
    dat = src[7:0] ^ src[23:16] ^ 8'h3c;
    check(24'(sIll), 24'(!legal), "illegal");
    check(24'(sBusy), 24'(legal), "busy");
    if (legal) check(sSrc, src, "source");
    if (legal && p && op[7:5] == 3'h2) check(24'({sSel, sReg}), 24'({op[4:3], dat}), "load");
    if (legal && !(p && op[7:5] == 3'h2)) check(sDst, dst, "dest");
    if (legal && !(p && op[7:5] == 3'h2)) check(24'(sWd), 24'(dat), "wdata");
  endtask
  initial begin
    void'($urandom(32'ha209));
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 512 && !hung; k++) begin
      run(k[8], k[7:0], (k % 3 == 0) ? 8'h80 : (k % 3 == 1) ? 8'h7f : 8'($urandom()));
    end
    summarize();
  end
endmodule
`default_nettype wire
